// ===== rtl/mstt_pkg.sv
// Constants shared by the multiplex section trail termination block
package mstt_pkg;
  // Frame geometry, zero-based rows and columns of a 9 x 270 octet frame
  localparam logic [3:0] ROW_LAST = 4'h8;
  localparam logic [8:0] COL_LAST = 9'h10d;
  localparam logic [3:0] RS_ROWS = 4'h3;
  localparam logic [8:0] OH_COLS = 9'h009;
  localparam logic [3:0] B2_ROW = 4'h4;
  localparam logic [8:0] B2_COLS = 9'h003;
  localparam logic [3:0] K2_ROW = 4'h4;
  localparam logic [8:0] K2_COL = 9'h006;
  localparam logic [3:0] M1_ROW = 4'h8;
  localparam logic [8:0] M1_COL = 9'h005;
  localparam logic [1:0] LANE_LAST = 2'h2;
  // Status byte bits 6 to 8 codes and remote error limits
  localparam logic [2:0] STATUS_RDI = 3'h6;
  localparam logic [2:0] STATUS_AIS = 3'h7;
  localparam logic [2:0] STATUS_OK = 3'h0;
  localparam logic [7:0] REI_MAX = 8'h18;
  localparam logic [6:0] FAR_MAX = 7'h18;
  localparam logic [7:0] ALL_ONES = 8'hff;
  // Remote defect state persistence in frames
  localparam logic [2:0] RDI_FRAMES = 3'h5;
  // Response limit for alarm insertion and status insertion
  localparam int CLK_NS = 5;
  localparam int RESP_LIMIT_NS = 250000;
  localparam int RESP_LIMIT_CYCLES = RESP_LIMIT_NS / CLK_NS;
  typedef enum logic {ALARM_IDLE, ALARM_ACTIVE} alarm_e;
endpackage

// ===== rtl/mstt_top.sv
// Multiplex section trail termination, source and sink
`timescale 1ns/10ps
module mstt_top import mstt_pkg::*; #(
  parameter int ALARM_FRAMES = 3,
  parameter int SEC_W = 18
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [7:0] src_data_in,
  input wire logic src_valid_in,
  input wire logic src_fs_in,
  input wire logic [7:0] remote_error_count_in,
  input wire logic remote_defect_in,
  output logic [7:0] src_data_out,
  output logic src_valid_out,
  output logic src_fs_out,
  input wire logic [7:0] snk_data_in,
  input wire logic snk_valid_in,
  input wire logic snk_fs_in,
  input wire logic server_fail_in,
  input wire logic monitored_mode_in,
  input wire logic alarm_report_enable_in,
  input wire logic second_tick_in,
  input wire logic [SEC_W-1:0] degrade_threshold_in,
  input wire logic [3:0] degrade_period_in,
  output logic [7:0] snk_data_out,
  output logic snk_valid_out,
  output logic snk_fs_out,
  output logic alarm_insert_action_out,
  output logic trail_fail_action_out,
  output logic trail_degrade_action_out,
  output logic remote_defect_out,
  output logic remote_defect_state_out,
  output logic reported_alarm_out,
  output logic [4:0] remote_error_count_out,
  output logic [SEC_W-1:0] near_block_errors_out,
  output logic [SEC_W-1:0] far_block_errors_out,
  output logic near_defect_second_out,
  output logic far_defect_second_out
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  function automatic logic [3:0] ones8(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  // ----------------------------------------
  // Source: overhead insertion and parity
  // ----------------------------------------
  logic [3:0] so_row, next_so_row;
  logic [8:0] so_col, next_so_col;
  logic [1:0] so_lane, next_so_lane;
  logic [23:0] so_acc, next_so_acc;
  logic [23:0] so_par, next_so_par;
  logic [7:0] next_src_data;
  logic [3:0] so_r;
  logic [8:0] so_c;
  logic so_at_b2, so_at_k2, so_at_m1;
  logic [7:0] so_rei;

  always_comb begin
    so_r = src_fs_in ? 4'h0 : so_row;
    so_c = src_fs_in ? 9'h000 : so_col;
    so_at_b2 = src_valid_in && so_r == B2_ROW && so_c < B2_COLS;
    so_at_k2 = src_valid_in && so_r == K2_ROW && so_c == K2_COL;
    so_at_m1 = src_valid_in && so_r == M1_ROW && so_c == M1_COL;
    // Counts above 24 cannot come from a 24-bit check, clamp keeps the byte legal
    so_rei = (remote_error_count_in > REI_MAX) ? REI_MAX : remote_error_count_in;
    next_so_row = so_row;
    next_so_col = so_col;
    next_so_lane = so_lane;
    next_so_acc = so_acc;
    next_so_par = so_par;
    next_src_data = src_data_in;
    if (so_at_b2) begin
      next_src_data = so_par[{so_c[1:0], 3'h0} +: 8];
    end
    if (so_at_k2) begin
      next_src_data[2:0] = remote_defect_in ? STATUS_RDI : STATUS_OK;
    end
    if (so_at_m1) begin
      next_src_data = so_rei;
    end
    if (src_valid_in) begin
      if (src_fs_in) begin
        next_so_par = so_acc;
        next_so_acc = 24'h000000;
        next_so_lane = 2'h0;
      end
      // Parity covers the bytes as sent, so inserted overhead is included
      if (!(so_r < RS_ROWS && so_c < OH_COLS)) begin
        next_so_acc[{(src_fs_in ? 2'h0 : so_lane), 3'h0} +: 8] =
          next_so_acc[{(src_fs_in ? 2'h0 : so_lane), 3'h0} +: 8] ^ next_src_data;
      end
      next_so_lane = ((src_fs_in ? 2'h0 : so_lane) == LANE_LAST) ? 2'h0 :
                     (src_fs_in ? 2'h1 : so_lane + 2'h1);
      next_so_col = (so_c == COL_LAST) ? 9'h000 : so_c + 9'h001;
      next_so_row = (so_c != COL_LAST) ? so_r : (so_r == ROW_LAST) ? 4'h0 : so_r + 4'h1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      so_row <= 4'h0;
      so_col <= 9'h000;
      so_lane <= 2'h0;
      so_acc <= 24'h000000;
      so_par <= 24'h000000;
      src_data_out <= 8'h00;
      src_valid_out <= 1'b0;
      src_fs_out <= 1'b0;
    end else begin
      so_row <= next_so_row;
      so_col <= next_so_col;
      so_lane <= next_so_lane;
      so_acc <= next_so_acc;
      so_par <= next_so_par;
      src_data_out <= next_src_data;
      src_valid_out <= src_valid_in;
      src_fs_out <= src_fs_in && src_valid_in;
    end
  end

  // ----------------------------------------
  // Sink: parity check, overhead extraction, defects
  // ----------------------------------------
  logic [3:0] sk_row, next_sk_row;
  logic [8:0] sk_col, next_sk_col;
  logic [1:0] sk_lane, next_sk_lane;
  logic [23:0] sk_acc, next_sk_acc;
  logic [23:0] sk_par, next_sk_par;
  logic sk_seen, next_sk_seen;
  logic par_ok, next_par_ok;
  logic [4:0] sk_err, next_sk_err;
  logic [2:0] sk_k2, next_sk_k2;
  logic [6:0] sk_m1, next_sk_m1;
  alarm_e ais_state, next_ais_state;
  logic [2:0] ais_cnt, next_ais_cnt;
  logic rdi, next_rdi;
  logic [2:0] rdi_cnt, next_rdi_cnt;
  logic deg, next_deg;
  logic [3:0] deg_cnt, next_deg_cnt;
  logic [SEC_W-1:0] sec_near, next_sec_near, sec_far, next_sec_far;
  logic ds_near, next_ds_near, ds_far, next_ds_far;
  logic [3:0] sk_r;
  logic [8:0] sk_c;
  logic sk_at_b2, frame_end, ais_match, rdi_match, bad_sec;
  logic [6:0] sk_far;
  logic [4:0] add_near;

  always_comb begin
    sk_r = snk_fs_in ? 4'h0 : sk_row;
    sk_c = snk_fs_in ? 9'h000 : sk_col;
    sk_at_b2 = snk_valid_in && sk_r == B2_ROW && sk_c < B2_COLS;
    frame_end = snk_valid_in && snk_fs_in && sk_seen;
    sk_far = (sk_m1 > FAR_MAX) ? 7'h00 : sk_m1;
    add_near = (frame_end && par_ok) ? sk_err : 5'h00;
    ais_match = (sk_k2 == STATUS_AIS) ^ (ais_state == ALARM_ACTIVE);
    rdi_match = (sk_k2 == STATUS_RDI) ^ rdi;
    bad_sec = sec_near > degrade_threshold_in;
    next_sk_row = sk_row;
    next_sk_col = sk_col;
    next_sk_lane = sk_lane;
    next_sk_acc = sk_acc;
    next_sk_par = sk_par;
    next_sk_seen = sk_seen;
    next_par_ok = par_ok;
    next_sk_err = sk_err;
    next_sk_k2 = sk_k2;
    next_sk_m1 = sk_m1;
    next_ais_state = ais_state;
    next_ais_cnt = ais_cnt;
    next_rdi = rdi;
    next_rdi_cnt = rdi_cnt;
    next_deg = deg;
    next_deg_cnt = deg_cnt;
    next_ds_near = ds_near | (ais_state == ALARM_ACTIVE);
    next_ds_far = ds_far | rdi;
    if (frame_end) begin
      // Persistence counters run only while the frame disagrees with the state
      if (ais_match) begin
        next_ais_cnt = ais_cnt + 3'h1;
        if (ais_cnt == 3'(ALARM_FRAMES - 1)) begin
          next_ais_state = (ais_state == ALARM_ACTIVE) ? ALARM_IDLE : ALARM_ACTIVE;
          next_ais_cnt = 3'h0;
        end
      end else begin
        next_ais_cnt = 3'h0;
      end
      if (rdi_match) begin
        next_rdi_cnt = rdi_cnt + 3'h1;
        if (rdi_cnt == RDI_FRAMES - 3'h1) begin
          next_rdi = ~rdi;
          next_rdi_cnt = 3'h0;
        end
      end else begin
        next_rdi_cnt = 3'h0;
      end
    end
    if (snk_valid_in) begin
      if (snk_fs_in) begin
        next_sk_par = sk_acc;
        next_sk_acc = 24'h000000;
        next_sk_seen = 1'b1;
        next_par_ok = sk_seen;
        next_sk_err = 5'h00;
      end
      if (sk_at_b2 && par_ok) begin
        next_sk_err = sk_err + {1'b0, ones8(snk_data_in ^ sk_par[{sk_c[1:0], 3'h0} +: 8])};
      end
      if (sk_r == K2_ROW && sk_c == K2_COL) begin
        next_sk_k2 = snk_data_in[2:0];
      end
      if (sk_r == M1_ROW && sk_c == M1_COL) begin
        next_sk_m1 = snk_data_in[6:0];
      end
      if (!(sk_r < RS_ROWS && sk_c < OH_COLS)) begin
        next_sk_acc[{(snk_fs_in ? 2'h0 : sk_lane), 3'h0} +: 8] =
          next_sk_acc[{(snk_fs_in ? 2'h0 : sk_lane), 3'h0} +: 8] ^ snk_data_in;
      end
      next_sk_lane = ((snk_fs_in ? 2'h0 : sk_lane) == LANE_LAST) ? 2'h0 :
                     (snk_fs_in ? 2'h1 : sk_lane + 2'h1);
      next_sk_col = (sk_c == COL_LAST) ? 9'h000 : sk_c + 9'h001;
      next_sk_row = (sk_c != COL_LAST) ? sk_r : (sk_r == ROW_LAST) ? 4'h0 : sk_r + 4'h1;
    end
    // A frame closing on the tick cycle is charged to the new second
    next_sec_near = (second_tick_in ? '0 : sec_near) + SEC_W'(add_near);
    next_sec_far = (second_tick_in ? '0 : sec_far) +
                   SEC_W'(frame_end ? sk_far : 7'h00);
    if (second_tick_in) begin
      next_ds_near = ais_state == ALARM_ACTIVE;
      next_ds_far = rdi;
      // Degrade needs a full run of bad (or good) seconds to change
      if (bad_sec != deg) begin
        next_deg_cnt = deg_cnt + 4'h1;
        if (deg_cnt + 4'h1 >= degrade_period_in) begin
          next_deg = bad_sec;
          next_deg_cnt = 4'h0;
        end
      end else begin
        next_deg_cnt = 4'h0;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      sk_row <= 4'h0;
      sk_col <= 9'h000;
      sk_lane <= 2'h0;
      sk_acc <= 24'h000000;
      sk_par <= 24'h000000;
      sk_seen <= 1'b0;
      par_ok <= 1'b0;
      sk_err <= 5'h00;
      sk_k2 <= 3'h0;
      sk_m1 <= 7'h00;
      ais_state <= ALARM_IDLE;
      ais_cnt <= 3'h0;
      rdi <= 1'b0;
      rdi_cnt <= 3'h0;
      deg <= 1'b0;
      deg_cnt <= 4'h0;
      sec_near <= '0;
      sec_far <= '0;
      ds_near <= 1'b0;
      ds_far <= 1'b0;
      snk_data_out <= 8'h00;
      snk_valid_out <= 1'b0;
      snk_fs_out <= 1'b0;
      alarm_insert_action_out <= 1'b0;
      trail_fail_action_out <= 1'b0;
      trail_degrade_action_out <= 1'b0;
      remote_defect_out <= 1'b0;
      remote_defect_state_out <= 1'b0;
      reported_alarm_out <= 1'b0;
      remote_error_count_out <= 5'h00;
      near_block_errors_out <= '0;
      far_block_errors_out <= '0;
      near_defect_second_out <= 1'b0;
      far_defect_second_out <= 1'b0;
    end else begin
      sk_row <= next_sk_row;
      sk_col <= next_sk_col;
      sk_lane <= next_sk_lane;
      sk_acc <= next_sk_acc;
      sk_par <= next_sk_par;
      sk_seen <= next_sk_seen;
      par_ok <= next_par_ok;
      sk_err <= next_sk_err;
      sk_k2 <= next_sk_k2;
      sk_m1 <= next_sk_m1;
      ais_state <= next_ais_state;
      ais_cnt <= next_ais_cnt;
      rdi <= next_rdi;
      rdi_cnt <= next_rdi_cnt;
      deg <= next_deg;
      deg_cnt <= next_deg_cnt;
      sec_near <= next_sec_near;
      sec_far <= next_sec_far;
      ds_near <= next_ds_near;
      ds_far <= next_ds_far;
      snk_data_out <= (ais_state == ALARM_ACTIVE) ? ALL_ONES : snk_data_in;
      snk_valid_out <= snk_valid_in;
      snk_fs_out <= snk_fs_in && snk_valid_in;
      alarm_insert_action_out <= next_ais_state == ALARM_ACTIVE;
      trail_fail_action_out <= next_ais_state == ALARM_ACTIVE;
      remote_defect_out <= next_ais_state == ALARM_ACTIVE;
      trail_degrade_action_out <= next_deg;
      remote_defect_state_out <= next_rdi;
      reported_alarm_out <= monitored_mode_in && (next_ais_state == ALARM_ACTIVE) &&
                            !server_fail_in && alarm_report_enable_in;
      if (frame_end) begin
        remote_error_count_out <= add_near;
      end
      if (second_tick_in) begin
        near_block_errors_out <= sec_near;
        far_block_errors_out <= sec_far;
        near_defect_second_out <= next_ds_near | ds_near;
        far_defect_second_out <= next_ds_far | ds_far;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n);

  chk_rei_insert: assert property (so_at_m1 |=> src_data_out == $past(so_rei) && src_data_out <= REI_MAX)
    else $error("remote error byte wrong");
  chk_status_insert: assert property (so_at_k2 |=>
    src_data_out[2:0] == ($past(remote_defect_in) ? STATUS_RDI : STATUS_OK))
    else $error("status bits wrong");
  chk_parity_insert: assert property (so_at_b2 && so_c == 9'h001 |=>
    src_data_out == $past(so_par[15:8]))
    else $error("parity byte wrong");
  chk_parity_count: assert property (sk_at_b2 && par_ok && !snk_fs_in &&
    snk_data_in == ~sk_par[{sk_c[1:0], 3'h0} +: 8] |=> sk_err == $past(sk_err) + 5'h08)
    else $error("parity mismatch count wrong");
  chk_far_decode: assert property (frame_end && sk_m1 > FAR_MAX |=>
    sec_far == $past(second_tick_in ? '0 : sec_far))
    else $error("out of range far count not zero");
  chk_rdi_entry: assert property ($rose(remote_defect_state_out) |->
    $past(frame_end && sk_k2 == STATUS_RDI))
    else $error("remote defect state without pattern");
  chk_alarm_entry: assert property ($rose(alarm_insert_action_out) |->
    $past(frame_end && sk_k2 == STATUS_AIS && ais_cnt == 3'(ALARM_FRAMES - 1)))
    else $error("alarm defect raised early");
  chk_degrade_hold: assert property (!second_tick_in |=> $stable(trail_degrade_action_out))
    else $error("degrade changed off the tick");
  chk_ais_data: assert property (snk_valid_in && alarm_insert_action_out |=>
    snk_data_out == ALL_ONES)
    else $error("alarm insertion missing");
  chk_report_gate: assert property (reported_alarm_out |->
    alarm_insert_action_out && $past(monitored_mode_in && !server_fail_in))
    else $error("alarm reported without conditions");
  chk_fail_follow: assert property (trail_fail_action_out == remote_defect_out &&
    trail_fail_action_out == alarm_insert_action_out)
    else $error("consequent actions disagree");
  chk_second_latch: assert property (second_tick_in |=>
    near_block_errors_out == $past(sec_near) && far_block_errors_out == $past(sec_far))
    else $error("second counts not latched");

  cov_alarm_set: cover property ($rose(alarm_insert_action_out));
  cov_rdi_set: cover property ($rose(remote_defect_state_out));
  cov_degrade_set: cover property ($rose(trail_degrade_action_out));
  cov_reported: cover property (reported_alarm_out);

endmodule

// ===== verif/far_adapt_model.sv
// Far-side adaptation model that feeds framed octets to the sink
`timescale 1ns/10ps
module far_adapt_model import mstt_pkg::*; (
  input wire logic clock_in,
  input wire logic run_in,
  input wire logic [2:0] status_in,
  input wire logic [7:0] rei_in,
  input wire logic [23:0] mask_in,
  output logic [7:0] data_out,
  output logic valid_out,
  output logic fs_out,
  output logic [15:0] frame_num_out
);
  int idx = 0;
  int r;
  int c;
  logic [7:0] b;
  logic [23:0] acc = 24'h000000;
  logic [23:0] prev = 24'h000000;
  logic [2:0] st = 3'h0;
  logic [7:0] rei = 8'h00;
  logic [23:0] msk = 24'h000000;

  initial begin
    data_out = 8'h00;
    valid_out = 1'b0;
    fs_out = 1'b0;
    frame_num_out = 16'h0000;
  end

  always @(negedge clock_in) begin
    if (!run_in || $urandom_range(15) == 0) begin
      // Idle slot: the data lines must not keep showing the last octet
      valid_out <= 1'b0;
      fs_out <= 1'b0;
      data_out <= ~data_out;
    end else begin
      r = idx / 270;
      c = idx % 270;
      if (idx == 0) begin
        prev = acc;
        acc = 24'h000000;
        st = status_in;
        rei = rei_in;
        msk = mask_in;
        frame_num_out <= frame_num_out + 16'h0001;
      end
      b = 8'($urandom);
      if (r == B2_ROW && c < B2_COLS) b = prev[c*8 +: 8] ^ msk[c*8 +: 8];
      if (r == K2_ROW && c == K2_COL) b[2:0] = st;
      // Raw byte, so values above 24 and bit 1 set can be sent on purpose
      if (r == M1_ROW && c == M1_COL) b = rei;
      if (!(r < RS_ROWS && c < OH_COLS)) acc[(c % 3)*8 +: 8] = acc[(c % 3)*8 +: 8] ^ b;
      data_out <= b;
      valid_out <= 1'b1;
      fs_out <= (idx == 0);
      idx = (idx == 2429) ? 0 : idx + 1;
    end
  end
endmodule

// ===== verif/mstt_top_tb.sv
// Self-checking bench for the multiplex section trail termination block
`timescale 1ns/10ps
module mstt_top_tb import mstt_pkg::*; ;
  localparam int ALARM_X = 4;
  localparam int CNT_W = 18;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] src_data_in = 8'h00;
  logic src_valid_in = 1'b0;
  logic src_fs_in = 1'b0;
  logic [7:0] remote_error_count_in = 8'h00;
  logic remote_defect_in = 1'b0;
  logic [7:0] snk_data_in;
  logic snk_valid_in, snk_fs_in;
  logic server_fail_in = 1'b0;
  logic monitored_mode_in = 1'b1;
  logic alarm_report_enable_in = 1'b1;
  logic second_tick_in = 1'b0;
  logic [CNT_W-1:0] degrade_threshold_in = 18'h00022;
  logic [3:0] degrade_period_in = 4'h1;
  logic [7:0] src_data_out, snk_data_out;
  logic src_valid_out, src_fs_out, snk_valid_out, snk_fs_out;
  logic alarm_insert_action_out, trail_fail_action_out, trail_degrade_action_out;
  logic remote_defect_out, remote_defect_state_out, reported_alarm_out;
  logic near_defect_second_out, far_defect_second_out;
  logic [4:0] remote_error_count_out;
  logic [CNT_W-1:0] near_block_errors_out, far_block_errors_out;
  logic run = 1'b0;
  logic [2:0] st_code = 3'h0;
  logic [7:0] rei_byte = 8'h00;
  logic [23:0] err_mask = 24'h000000;
  logic [15:0] frame_num;
  logic [9:0] exp_q[$];
  logic [9:0] note;
  logic [7:0] rei_tab [4] = '{8'h18, 8'h99, 8'h85, 8'h98};
  logic [23:0] mask_tab [4] = '{24'h000001, 24'hff0000, 24'h800100, 24'hffffff};
  int bad_count = 0;
  int n_compared = 0;

  always #2.5 clock_in = ~clock_in;

  mstt_top #(.ALARM_FRAMES(ALARM_X), .SEC_W(CNT_W)) mstt_top_i (
    .clock_in, .resetn_in, .src_data_in, .src_valid_in, .src_fs_in, .remote_error_count_in,
    .remote_defect_in, .src_data_out, .src_valid_out, .src_fs_out, .snk_data_in, .snk_valid_in,
    .snk_fs_in, .server_fail_in, .monitored_mode_in, .alarm_report_enable_in, .second_tick_in,
    .degrade_threshold_in, .degrade_period_in, .snk_data_out, .snk_valid_out, .snk_fs_out,
    .alarm_insert_action_out, .trail_fail_action_out, .trail_degrade_action_out,
    .remote_defect_out, .remote_defect_state_out, .reported_alarm_out, .remote_error_count_out,
    .near_block_errors_out, .far_block_errors_out, .near_defect_second_out,
    .far_defect_second_out
  );

  far_adapt_model far_adapt_model_i (
    .clock_in, .run_in(run), .status_in(st_code), .rei_in(rei_byte), .mask_in(err_mask),
    .data_out(snk_data_in), .valid_out(snk_valid_in), .fs_out(snk_fs_in),
    .frame_num_out(frame_num)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Settings given now reach the next frame; returns 3 cycles into the nth frame start
  task automatic play(input int n, input logic [2:0] st, input logic [7:0] rei,
                      input logic [23:0] msk);
    logic [15:0] k;
    st_code = st;
    rei_byte = rei;
    err_mask = msk;
    repeat (n) begin
      k = frame_num;
      wait (frame_num != k);
    end
    repeat (3) @(negedge clock_in);
  endtask

  // Ticks land a few cycles after a frame start, never on a frame end
  task automatic tick;
    @(negedge clock_in);
    second_tick_in = 1'b1;
    @(negedge clock_in);
    second_tick_in = 1'b0;
    repeat (2) @(negedge clock_in);
  endtask

  // ----------------------------------------
  // Source stream: back to back frames, expected octets noted in order
  // ----------------------------------------
  initial begin
    int i;
    int r;
    int c;
    logic [7:0] d;
    logic [7:0] e;
    logic [23:0] acc;
    logic [23:0] prev;
    logic first;
    acc = 24'h000000;
    prev = 24'h000000;
    first = 1'b1;
    wait (run);
    forever begin
      for (i = 0; i < 2430; i++) begin
        @(negedge clock_in);
        r = i / 270;
        c = i % 270;
        if (i == 0) begin
          prev = acc;
          acc = 24'h000000;
          remote_error_count_in = 8'($urandom_range(40));
          remote_defect_in = 1'($urandom_range(1));
        end
        d = 8'($urandom);
        e = d;
        if (r == B2_ROW && c < B2_COLS) e = prev[c*8 +: 8];
        if (r == K2_ROW && c == K2_COL) e[2:0] = remote_defect_in ? STATUS_RDI : STATUS_OK;
        if (r == M1_ROW && c == M1_COL) begin
          e = (remote_error_count_in > REI_MAX) ? REI_MAX : remote_error_count_in;
        end
        if (!(r < RS_ROWS && c < OH_COLS)) acc[(c % 3)*8 +: 8] = acc[(c % 3)*8 +: 8] ^ e;
        src_data_in = d;
        src_valid_in = 1'b1;
        src_fs_in = (i == 0);
        // No previous frame exists for the first parity bytes
        exp_q.push_back({first && r == B2_ROW && c < B2_COLS, i == 0, e});
      end
      first = 1'b0;
    end
  end

  // Outputs launched at the rising edge are read at the following falling edge
  always @(negedge clock_in) begin
    if (src_valid_out === 1'b1) begin
      note = exp_q.pop_front();
      if (note[9] !== 1'b1) check({src_fs_out, src_data_out}, note[8:0]);
    end
  end

  // ----------------------------------------
  // Sink scenarios
  // ----------------------------------------
  initial begin
    int i;
    int nsum;
    int fsum;
    logic [7:0] d;
    logic [1:0] v;
    void'($urandom(32'h94c325a9));
    repeat (5) @(negedge clock_in);
    resetn_in = 1'b1;
    repeat (3) @(negedge clock_in);
    run = 1'b1;
    play(3, STATUS_OK, 8'h00, 24'h000000);
    tick();
    nsum = 0;
    fsum = 0;
    for (i = 0; i < 4; i++) begin
      play(1, STATUS_OK, rei_tab[i], mask_tab[i]);
      check(remote_error_count_out, (i == 0) ? 0 : $countones(mask_tab[i-1]));
      nsum += $countones(mask_tab[i]);
      fsum += (rei_tab[i][6:0] > FAR_MAX) ? 0 : int'(rei_tab[i][6:0]);
    end
    play(1, STATUS_OK, 8'h00, 24'h000000);
    check(remote_error_count_out, 24);
    tick();
    check(near_block_errors_out, nsum);
    check(far_block_errors_out, fsum);
    check(trail_degrade_action_out, 1);
    check(reported_alarm_out, 0);
    play(2, STATUS_OK, 8'h00, 24'h000000);
    tick();
    check(near_block_errors_out, 0);
    check(far_block_errors_out, 0);
    check(trail_degrade_action_out, 0);
    play(ALARM_X, STATUS_AIS, 8'h00, 24'h000000);
    check(alarm_insert_action_out, 0);
    play(1, STATUS_AIS, 8'h00, 24'h000000);
    check({alarm_insert_action_out, trail_fail_action_out, remote_defect_out}, 3'h7);
    check(snk_data_out, ALL_ONES);
    for (i = 0; i < 8; i++) begin
      monitored_mode_in = i[0];
      server_fail_in = !i[1];
      alarm_report_enable_in = i[2];
      repeat (2) @(negedge clock_in);
      check(reported_alarm_out, i == 7);
    end
    tick();
    check({near_defect_second_out, far_defect_second_out}, 2'h2);
    play(ALARM_X, STATUS_RDI, 8'h00, 24'h000000);
    check(alarm_insert_action_out, 1);
    play(1, STATUS_RDI, 8'h00, 24'h000000);
    check({alarm_insert_action_out, reported_alarm_out, remote_defect_state_out}, 0);
    @(posedge clock_in);
    d = snk_data_in;
    v = {snk_fs_in && snk_valid_in, snk_valid_in};
    @(negedge clock_in);
    check(snk_data_out, d);
    check({snk_fs_out, snk_valid_out}, v);
    play(1, STATUS_RDI, 8'h00, 24'h000000);
    check({remote_defect_state_out, remote_defect_out}, 2'h2);
    tick();
    check(far_defect_second_out, 1);
    // A silent source output would leave its notes piling up unchecked
    check(exp_q.size() < 3, 1);
    tally_and_finish();
  end

  // Run needs about 52k cycles; the limit leaves a wide margin
  initial begin
    #400000;
    bad_count++;
    tally_and_finish();
  end
endmodule
